/* File: hdl/adcc_pkg.sv */
package adcc_pkg;
   // ==========================================
   // Register map
   localparam logic [11:0] CTL0_ADDR = 12'h0f70;
   localparam logic [11:0] CTL1_ADDR = 12'h0f71;
   localparam logic [11:0] STAT_ADDR = 12'h0f74;
   localparam logic [7:0] CTL0_RST = 8'h00;
   localparam logic [7:0] CTL1_RST = 8'h80;
   localparam logic [7:0] CTL1_WMASK = 8'h0087;
   // ==========================================
   // Field positions
   localparam int START_POS = 7;
   localparam int REFL_POS = 6;
   localparam int REF_BUFFER_DRIVE_ENABLE_POS = 5;
   localparam int CONTINUOUS_MODE_BIT_POS = 4;
   localparam int REFH_POS = 7;
   localparam int BUFM_DIFF_POS = 2;
   // ==========================================
   // Input codes and reference codes
   localparam logic [3:0] SEL_LAST_SE = 4'h0007;
   localparam logic [3:0] SEL_TEMP = 4'h000e;
   localparam logic [3:0] SEL_HOLD = 4'h000c;
   localparam logic [3:0] SEL_LAST_DIFF = 4'h000a;
   localparam logic [3:0] SEL_OFFSET = 4'h000f;
   localparam logic [1:0] REF_EXT = 2'h0;
   localparam logic [1:0] REF_1V0 = 2'h1;
   localparam logic [1:0] REF_2V0 = 2'h2;
   // ==========================================
   // Timing
   localparam int FIRST_CLKS = 5129;
   localparam int CONTINUOUS_MODE_BIT_CLKS = 256;
   localparam int TEMP_FACTOR = 2;

   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_FIRST = 2'b01,
      ADCC_CONTINUOUS_MODE_BIT = 2'b10
   } adcc_state_t;

   // Analog core controls
   typedef struct packed {
      logic int_ref_en;
      logic ref_1v0;
      logic ref_2v0;
      logic ref_buf_en;
      logic diff_mode;
      logic switches_open;
      logic offset_short;
      logic temp_sel;
      logic [3:0] channel;
   } adcc_analog_t;
endpackage

/* File: hdl/adcc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_timer #(
   parameter int CW = 14
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Control
   input wire logic load,
   input wire logic clear,
   input wire logic [CW-1:0] load_val,
   // Status
   output logic expire
);
   logic [CW-1:0] cnt_r;
   logic run_r;

   always_ff @(posedge mclk) begin
      if (srst || clear) begin
         cnt_r <= '0;
         run_r <= 1'b0;
      end else if (load) begin
         cnt_r <= load_val - CW'(1);
         run_r <= 1'b1;
      end else if (run_r) begin
         if (cnt_r == '0) begin
            run_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - CW'(1);
         end
      end
   end

   // Not gated by load: reload is fed back from expire
   assign expire = run_r && (cnt_r == '0) && !clear;
endmodule
`default_nettype wire

/* File: hdl/adcc_ctrl.sv */
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl #(
   parameter int FIRST_CLKS = adcc_pkg::FIRST_CLKS,
   parameter int CONTINUOUS_MODE_BIT_CLKS = adcc_pkg::CONTINUOUS_MODE_BIT_CLKS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Avalon-MM slave
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_writedata,
   output logic [7:0] avs_readdata,
   output logic avs_waitrequest,
   // Analog core
   output adcc_pkg::adcc_analog_t analog_ctl,
   output logic sample_strobe
);
   localparam int CW = $clog2(FIRST_CLKS * adcc_pkg::TEMP_FACTOR + 1);

   logic [7:0] ctl0_r;
   logic [7:0] ctl1_r;
   logic ack_r;
   logic done_r;
   adcc_pkg::adcc_state_t state_r;
   logic tm_load, tm_expire;
   logic [CW-1:0] tm_val;
   logic wr_ctl0, wr_ctl1;
   logic [1:0] ref_sel;
   logic diff_m;
   logic [3:0] sel;

   function automatic logic sel_valid(input logic [3:0] s, input logic d);
      if (d) begin
         sel_valid = (s <= adcc_pkg::SEL_LAST_DIFF) ||
                     (s == adcc_pkg::SEL_OFFSET);
      end else begin
         sel_valid = (s <= adcc_pkg::SEL_LAST_SE) ||
                     (s == adcc_pkg::SEL_TEMP) || (s == adcc_pkg::SEL_HOLD);
      end
   endfunction

   function automatic logic [CW-1:0] dur(input int base, input logic t);
      dur = t ? CW'(base * adcc_pkg::TEMP_FACTOR) : CW'(base);
   endfunction

   // ==========================================
   // Bus slave: one wait cycle per access
   assign wr_ctl0 = avs_write && ack_r && (avs_address == adcc_pkg::CTL0_ADDR);
   assign wr_ctl1 = avs_write && ack_r && (avs_address == adcc_pkg::CTL1_ADDR);

   always_ff @(posedge mclk) begin
      if (srst || ack_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= avs_read || avs_write;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         avs_readdata <= 8'h00;
      end else if (avs_read && !ack_r) begin
         case (avs_address)
            adcc_pkg::CTL0_ADDR: avs_readdata <= ctl0_r;
            adcc_pkg::CTL1_ADDR: avs_readdata <= ctl1_r;
            adcc_pkg::STAT_ADDR: avs_readdata <= {6'h00, state_r != adcc_pkg::ADCC_IDLE, done_r};
            default: avs_readdata <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // Control registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctl0_r <= adcc_pkg::CTL0_RST;
      end else begin
         if (wr_ctl0) begin
            ctl0_r[adcc_pkg::START_POS-1:0] <= avs_writedata[adcc_pkg::START_POS-1:0];
            if (avs_writedata[adcc_pkg::START_POS]) begin
               ctl0_r[adcc_pkg::START_POS] <= 1'b1;
            end
         end
         if (tm_expire && state_r != adcc_pkg::ADCC_IDLE &&
             !ctl0_r[adcc_pkg::CONTINUOUS_MODE_BIT_POS]) begin
            ctl0_r[adcc_pkg::START_POS] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctl1_r <= adcc_pkg::CTL1_RST;
      end else if (wr_ctl1) begin
         ctl1_r <= avs_writedata & adcc_pkg::CTL1_WMASK;
      end
   end

   // ==========================================
   // Sequencer
   assign sel = ctl0_r[3:0];
   assign diff_m = ctl1_r[adcc_pkg::BUFM_DIFF_POS];
   assign tm_val = dur(state_r == adcc_pkg::ADCC_IDLE ? FIRST_CLKS : CONTINUOUS_MODE_BIT_CLKS,
                       !diff_m && sel == adcc_pkg::SEL_TEMP);
   assign tm_load = (state_r == adcc_pkg::ADCC_IDLE && ctl0_r[adcc_pkg::START_POS]) ||
                    (tm_expire && ctl0_r[adcc_pkg::CONTINUOUS_MODE_BIT_POS]);

   adcc_timer #(.CW(CW)) u_timer (
      .mclk(mclk),
      .srst(srst),
      .load(tm_load),
      .clear(1'b0),
      .load_val(tm_val),
      .expire(tm_expire)
   );

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= adcc_pkg::ADCC_IDLE;
      end else begin
         case (state_r)
            adcc_pkg::ADCC_IDLE: if (ctl0_r[adcc_pkg::START_POS]) begin
               state_r <= adcc_pkg::ADCC_FIRST;
            end
            adcc_pkg::ADCC_FIRST, adcc_pkg::ADCC_CONTINUOUS_MODE_BIT: if (tm_expire) begin
               state_r <= ctl0_r[adcc_pkg::CONTINUOUS_MODE_BIT_POS] ? adcc_pkg::ADCC_CONTINUOUS_MODE_BIT :
                          adcc_pkg::ADCC_IDLE;
            end
            default: state_r <= adcc_pkg::ADCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sample_strobe <= 1'b0;
         done_r <= 1'b0;
      end else begin
         sample_strobe <= tm_expire;
         if (tm_expire) begin
            done_r <= 1'b1;
         end else if (wr_ctl0 && avs_writedata[adcc_pkg::START_POS]) begin
            done_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // Analog controls; comparator reference lives elsewhere
   assign ref_sel = {ctl1_r[adcc_pkg::REFH_POS], ctl0_r[adcc_pkg::REFL_POS]};
   always_ff @(posedge mclk) begin
      if (srst) begin
         analog_ctl <= '0;
      end else begin
         analog_ctl.int_ref_en <= ref_sel == adcc_pkg::REF_1V0 ||
                                  ref_sel == adcc_pkg::REF_2V0;
         analog_ctl.ref_1v0 <= ref_sel == adcc_pkg::REF_1V0;
         analog_ctl.ref_2v0 <= ref_sel == adcc_pkg::REF_2V0;
         analog_ctl.ref_buf_en <= ctl0_r[adcc_pkg::REF_BUFFER_DRIVE_ENABLE_POS];
         analog_ctl.diff_mode <= diff_m;
         analog_ctl.switches_open <= !sel_valid(sel, diff_m);
         analog_ctl.offset_short <= diff_m && sel == adcc_pkg::SEL_OFFSET;
         analog_ctl.temp_sel <= !diff_m && sel == adcc_pkg::SEL_TEMP;
         analog_ctl.channel <= sel;
      end
   end

   // ==========================================
   // Checks
   property p_wait_one;
      @(posedge mclk) disable iff (srst)
      ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus wait not one cycle");

   property p_ref_2v0;
      @(posedge mclk) disable iff (srst)
      (ref_sel == adcc_pkg::REF_2V0) |=> analog_ctl.ref_2v0 && !analog_ctl.ref_1v0;
   endproperty
   a_ref_2v0: assert property (p_ref_2v0) else $error("2.0 V ref decode wrong");

   property p_ref_ext;
      @(posedge mclk) disable iff (srst)
      (ref_sel == adcc_pkg::REF_EXT) |=> !analog_ctl.int_ref_en;
   endproperty
   a_ref_ext: assert property (p_ref_ext) else $error("external ref not honoured");

   property p_ref_mix;
      @(posedge mclk) disable iff (srst)
      1'b1 |=> analog_ctl.int_ref_en == ($past(ctl1_r[adcc_pkg::REFH_POS]) ^ $past(ctl0_r[adcc_pkg::REFL_POS]));
   endproperty
   a_ref_mix: assert property (p_ref_mix) else $error("ref selector concat wrong");

   property p_start_first;
      @(posedge mclk) disable iff (srst)
      (state_r == adcc_pkg::ADCC_IDLE && ctl0_r[adcc_pkg::START_POS]) |=> !sample_strobe[*8];
   endproperty
   a_start_first: assert property (p_start_first) else $error("early result");

   property p_single_clear;
      @(posedge mclk) disable iff (srst)
      (tm_expire && state_r == adcc_pkg::ADCC_FIRST && !ctl0_r[adcc_pkg::CONTINUOUS_MODE_BIT_POS])
         |=> !ctl0_r[adcc_pkg::START_POS] || $past(wr_ctl0);
   endproperty
   a_single_clear: assert property (p_single_clear) else $error("start not cleared");

   property p_continuous_mode_bit_period;
      @(posedge mclk) disable iff (srst)
      (tm_expire && state_r == adcc_pkg::ADCC_CONTINUOUS_MODE_BIT && ctl0_r[adcc_pkg::CONTINUOUS_MODE_BIT_POS] && sel != adcc_pkg::SEL_TEMP)
         |=> !tm_expire[*7];
   endproperty
   a_continuous_mode_bit_period: assert property (p_continuous_mode_bit_period) else $error("refresh too soon");

   property p_reserved_open;
      @(posedge mclk) disable iff (srst)
      (!diff_m && sel == 4'h000d) |=> analog_ctl.switches_open;
   endproperty
   a_reserved_open: assert property (p_reserved_open) else $error("reserved code closed switch");

   property p_offset;
      @(posedge mclk) disable iff (srst)
      (diff_m && sel == adcc_pkg::SEL_OFFSET) |=> analog_ctl.offset_short && !analog_ctl.switches_open;
   endproperty
   a_offset: assert property (p_offset) else $error("offset short missing");

   property p_temp;
      @(posedge mclk) disable iff (srst)
      (!diff_m && sel == adcc_pkg::SEL_TEMP) |=> analog_ctl.temp_sel;
   endproperty
   a_temp: assert property (p_temp) else $error("temp select missing");

   property p_cv_single;
      @(posedge mclk) disable iff (srst)
      state_r == adcc_pkg::ADCC_FIRST ##1 state_r == adcc_pkg::ADCC_IDLE;
   endproperty
   c_single: cover property (p_cv_single);

   property p_cv_continuous_mode_bit;
      @(posedge mclk) disable iff (srst)
      state_r == adcc_pkg::ADCC_CONTINUOUS_MODE_BIT && tm_expire;
   endproperty
   c_continuous_mode_bit: cover property (p_cv_continuous_mode_bit);

   property p_cv_temp;
      @(posedge mclk) disable iff (srst)
      analog_ctl.temp_sel && sample_strobe;
   endproperty
   c_temp: cover property (p_cv_temp);
endmodule
`default_nettype wire

/* File: dv/adcc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Converter core stand-in: counts results
module adcc_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // From control
   input wire adcc_pkg::adcc_analog_t analog_ctl,
   input wire logic sample_strobe,
   // Observation
   output logic [15:0] n_results,
   output logic [3:0] last_chan
);
   always_ff @(posedge mclk) begin
      if (srst) begin
         n_results <= 16'h0000;
         last_chan <= 4'h0;
      end else if (sample_strobe) begin
         n_results <= n_results + 16'h0001;
         last_chan <= analog_ctl.channel;
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb_adc_control_register_zero.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_register_zero;
   localparam int NF = 20;
   localparam int NC = 8;
   logic mclk, srst, avs_read, avs_write, avs_waitrequest, sample_strobe;
   logic [11:0] avs_address;
   logic [7:0] avs_writedata, avs_readdata, q;
   adcc_pkg::adcc_analog_t analog_ctl;
   logic [15:0] n_results;
   logic [3:0] last_chan;
   logic [2:0] ex [4] = '{3'b000, 3'b110, 3'b101, 3'b000};
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int t0 = 0;

   adcc_ctrl #(.FIRST_CLKS(NF), .CONTINUOUS_MODE_BIT_CLKS(NC)) adcc_ctrl_i (
      .mclk(mclk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .analog_ctl(analog_ctl),
      .sample_strobe(sample_strobe));
   adcc_core_model adcc_core_model_i (
      .mclk(mclk), .srst(srst), .analog_ctl(analog_ctl),
      .sample_strobe(sample_strobe), .n_results(n_results),
      .last_chan(last_chan));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bus(input logic rd, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge mclk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge mclk);
      while (avs_waitrequest) @(posedge mclk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      bus(1'b1, a, 8'h00);
      chk({8'h00, q}, {8'h00, e});
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wait_in(input int lo, input int hi);
      while (!sample_strobe && cyc - t0 < 30000) @(posedge mclk);
      chk(16'((cyc - t0 >= lo) && (cyc - t0 <= hi)), 16'h0001);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs();
      do_reset();
      rd_chk(adcc_pkg::CTL0_ADDR, 8'h00);
      rd_chk(adcc_pkg::CTL1_ADDR, 8'h80);
      chk({13'h0, analog_ctl.int_ref_en, analog_ctl.ref_1v0,
           analog_ctl.ref_2v0}, 16'h0005);
      wr(adcc_pkg::CTL0_ADDR, 8'h75);
      rd_chk(adcc_pkg::CTL0_ADDR, 8'h75);
      wr(adcc_pkg::CTL1_ADDR, 8'hff);
      rd_chk(adcc_pkg::CTL1_ADDR, 8'h87);
      wr(12'hf7f, 8'hff);
      rd_chk(12'hf7f, 8'h00);
   endtask
   task automatic t_ref();
      for (int i = 0; i < 4; i++) begin
         wr(adcc_pkg::CTL1_ADDR, i[1] ? 8'h80 : 8'h00);
         wr(adcc_pkg::CTL0_ADDR, i[0] ? 8'h60 : 8'h00);
         repeat (2) @(posedge mclk);
         chk({13'h0, analog_ctl.int_ref_en, analog_ctl.ref_1v0,
              analog_ctl.ref_2v0}, {13'h0, ex[i]});
         chk(16'(analog_ctl.ref_buf_en), 16'(i[0]));
      end
   endtask
   task automatic sel(input logic [7:0] c1, input logic [3:0] code,
                      input logic [2:0] fl);
      wr(adcc_pkg::CTL1_ADDR, c1);
      wr(adcc_pkg::CTL0_ADDR, {4'h0, code});
      repeat (2) @(posedge mclk);
      chk({13'h0, analog_ctl.switches_open, analog_ctl.offset_short,
           analog_ctl.temp_sel}, {13'h0, fl});
      chk(16'(analog_ctl.diff_mode), 16'(c1[2]));
   endtask
   task automatic t_sel();
      for (int i = 0; i < 8; i++) begin
         sel(8'h00, 4'(i), 3'b000);
         chk({12'h0, analog_ctl.channel}, 16'(i));
      end
      sel(8'h00, adcc_pkg::SEL_TEMP, 3'b001);
      sel(8'h00, 4'h9, 3'b100);
      sel(8'h04, adcc_pkg::SEL_OFFSET, 3'b010);
      sel(8'h04, 4'hb, 3'b100);
      sel(8'h00, adcc_pkg::SEL_HOLD, 3'b000);
      sel(8'h00, 4'hd, 3'b100);
      sel(8'h04, adcc_pkg::SEL_LAST_DIFF, 3'b000);
      sel(8'h04, adcc_pkg::SEL_TEMP, 3'b100);
   endtask
   task automatic t_single();
      do_reset();
      t0 = cyc;
      wr(adcc_pkg::CTL0_ADDR, 8'h83);
      repeat (5) @(posedge mclk);
      wr(adcc_pkg::CTL0_ADDR, 8'h83);
      wait_in(NF + 1, NF + 5);
      repeat (3 * NF) @(posedge mclk);
      chk(n_results, 16'h0001);
      chk({12'h0, last_chan}, 16'h0003);
      rd_chk(adcc_pkg::CTL0_ADDR, 8'h03);
      rd_chk(adcc_pkg::STAT_ADDR, 8'h01);
   endtask
   task automatic t_temp();
      do_reset();
      t0 = cyc;
      wr(adcc_pkg::CTL0_ADDR, 8'h8e);
      wait_in(2 * NF + 1, 2 * NF + 5);
   endtask
   task automatic t_continuous_mode_bit();
      do_reset();
      t0 = cyc;
      wr(adcc_pkg::CTL0_ADDR, 8'h93);
      wait_in(NF + 1, NF + 5);
      t0 = cyc;
      @(posedge mclk);
      wait_in(NC, NC);
      wr(adcc_pkg::CTL0_ADDR, 8'h9e);
      t0 = cyc;
      wait_in(1, NC);
      t0 = cyc;
      @(posedge mclk);
      wait_in(2 * NC, 2 * NC);
      do_reset();
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial begin
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 12'h000;
      avs_writedata = 8'h00;
      t_regs();
      t_ref();
      t_sel();
      t_single();
      t_temp();
      t_continuous_mode_bit();
      conclude();
   end
   initial begin
      #(25 * 20000);
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
